/* File: logic/flow_pulse_emitter.sv */
// Functional notes
// - measurements run on fixed repeating schedule
// - fast mode only changes measurement rate
// - output held off sixteen seconds after power-up
// - pulse rate linear in flow
// - no pulses below cut-off or reverse
// - clamp at 125 pulses per second
// - saturation equals 125 over meter factor
// - pulse count recomputed and emitted each second
// - pulse high time within 2 to 5 ms
// - about 30 ms pause between bursts
// - pulse count from averaged flow measurements
// - averaging tail at most eight seconds
// - time difference from phase measurement
// - sound speed from several transit times
// - flow equals dt c squared area over 2l
// - volume integrates flow rate over time
`timescale 1ns/1ns
module flow_pulse_emitter #(
   parameter int SECOND_CYC = flow_pulse_pkg::SECOND_CYC,
   parameter int FAST_MEAS_CYC = flow_pulse_pkg::FAST_MEAS_CYC,
   parameter int WARMUP_CYC = flow_pulse_pkg::WARMUP_CYC,
   parameter int PULSE_HIGH_CYC = flow_pulse_pkg::PULSE_HIGH_CYC,
   parameter int PULSE_GAP_CYC = flow_pulse_pkg::PULSE_GAP_CYC,
   parameter int BURST_PAUSE_CYC = flow_pulse_pkg::BURST_PAUSE_CYC,
   parameter logic [31:0] MIN_CUT = flow_pulse_pkg::MIN_CUT_DEF,
   parameter logic [15:0] GAIN = flow_pulse_pkg::GAIN_DEF
)(
   input wire logic clk, // 10 MHz clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic test_mode, // pin: fast measurement mode
   input wire logic [15:0] meter_factor, // pulses per litre in tenths
   input wire logic meas_done, // front end result valid
   input wire logic [15:0] meas_value, // transit time or signed phase
   output logic meas_start_q, // one-cycle measurement request
   output logic meas_is_phase_q, // request is phase, else transit time
   output logic pulse_out_q, // flow pulse line
   output logic ready_q, // warm-up finished
   output logic [31:0] flow_rate_q, // averaged rate, milli-pulses/s
   output logic [47:0] volume_q // volume in milli-pulses
);

   // ----------------------------------------
   // pin synchroniser and timebase
   // ----------------------------------------
   logic test_meta_q, test_q;
   logic [27:0] sec_cnt_q, sub_cnt_q, warm_cnt_q;
   wire sec_tick = (sec_cnt_q == 28'(SECOND_CYC - 1));
   wire sub_tick = (sub_cnt_q == 28'(FAST_MEAS_CYC - 1));
   wire meas_tick = test_q ? (sec_tick | sub_tick) : sec_tick;

   // two flops on the test mode pin
   always_ff @(posedge clk)
   begin
      test_meta_q <= rst_n ? test_mode : 1'b0;
      test_q <= rst_n ? test_meta_q : 1'b0;
   end

   // second counter, fast sub-period counter, warm-up holdoff
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sec_cnt_q <= 28'h000_0000;
         sub_cnt_q <= 28'h000_0000;
         warm_cnt_q <= 28'h000_0000;
         ready_q <= 1'b0;
      end
      else
      begin
         sec_cnt_q <= sec_tick ? 28'h000_0000 : sec_cnt_q + 28'h000_0001;
         sub_cnt_q <= (sec_tick | sub_tick) ? 28'h000_0000 : sub_cnt_q + 28'h000_0001;
         if (warm_cnt_q == 28'(WARMUP_CYC - 1))
            ready_q <= 1'b1;
         else
            warm_cnt_q <= warm_cnt_q + 28'h000_0001;
      end
   end

   // ----------------------------------------
   // measurement sequencer
   // ----------------------------------------
   flow_pulse_pkg::seq_state_t st_q, st_d;
   logic [2:0] tof_n_q;
   logic [17:0] tof_sum_q;
   logic signed [15:0] dt_q;
   logic [5:0] div_n_q;
   logic [47:0] num_q, quo_q;
   logic [32:0] rem_q;
   logic [31:0] den_q;

   wire [15:0] tof_avg = 16'(tof_sum_q >> flow_pulse_pkg::TOF_SHIFT);
   wire [31:0] tof_sq = 32'(tof_avg) * 32'(tof_avg);
   // divider loads on the phase answer edge, so the fresh phase is taken there
   wire phase_in = (st_q == flow_pulse_pkg::ST_PHASE) && meas_done;
   wire [15:0] dt_now = phase_in ? meas_value : dt_q;
   wire [15:0] dt_mag = dt_now[15] ? 16'(-dt_now) : dt_now;
   wire [47:0] num_start = 48'(dt_mag) * 48'(meter_factor) * 48'(GAIN);
   wire [32:0] rem_shift = {rem_q[31:0], num_q[47]};
   wire rem_ge = rem_shift >= {1'b0, den_q};
   wire tof_last = (tof_n_q == flow_pulse_pkg::TOF_SAMPLES - 3'h1);
   wire div_last = (div_n_q == flow_pulse_pkg::DIV_STEPS - 6'h01);

   // next state of the sequence
   always_comb
   begin
      st_d = st_q;
      case (st_q)
         flow_pulse_pkg::ST_IDLE: if (meas_tick) st_d = flow_pulse_pkg::ST_TOF;
         flow_pulse_pkg::ST_TOF: if (meas_done && tof_last) st_d = flow_pulse_pkg::ST_PHASE;
         flow_pulse_pkg::ST_PHASE: if (meas_done) st_d = flow_pulse_pkg::ST_DIV;
         flow_pulse_pkg::ST_DIV: if (div_last) st_d = flow_pulse_pkg::ST_IDLE;
         default: st_d = flow_pulse_pkg::ST_IDLE;
      endcase
   end

   // requests to the front end and result capture
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_q <= flow_pulse_pkg::ST_IDLE;
         meas_start_q <= 1'b0;
         meas_is_phase_q <= 1'b0;
         tof_n_q <= 3'h0;
         tof_sum_q <= 18'h0_0000;
         dt_q <= 16'sh0000;
      end
      else
      begin
         st_q <= st_d;
         meas_start_q <= (st_q == flow_pulse_pkg::ST_IDLE && meas_tick)
            || (st_q == flow_pulse_pkg::ST_TOF && meas_done);
         if (st_q == flow_pulse_pkg::ST_TOF && meas_done && tof_last)
            meas_is_phase_q <= 1'b1;
         else if (st_q != flow_pulse_pkg::ST_TOF)
            meas_is_phase_q <= (st_q == flow_pulse_pkg::ST_PHASE);
         if (st_q == flow_pulse_pkg::ST_IDLE)
         begin
            tof_n_q <= 3'h0;
            tof_sum_q <= 18'h0_0000;
         end
         else if (st_q == flow_pulse_pkg::ST_TOF && meas_done)
         begin
            tof_n_q <= tof_n_q + 3'h1;
            tof_sum_q <= tof_sum_q + 18'(meas_value);
         end
         if (st_q == flow_pulse_pkg::ST_PHASE && meas_done)
            dt_q <= meas_value;
      end
   end

   // ----------------------------------------
   // rate divider: dt * mf * gain / tof^2
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n || st_q != flow_pulse_pkg::ST_DIV)
      begin
         div_n_q <= 6'h00;
         num_q <= num_start;
         den_q <= tof_sq;
         rem_q <= 33'h0_0000_0000;
         quo_q <= 48'h0000_0000_0000;
      end
      else
      begin
         div_n_q <= div_n_q + 6'h01;
         num_q <= {num_q[46:0], 1'b0};
         rem_q <= rem_ge ? rem_shift - {1'b0, den_q} : rem_shift;
         quo_q <= {quo_q[46:0], rem_ge};
      end
   end

   // ----------------------------------------
   // averaging over samples and seconds
   // ----------------------------------------
   logic signed [35:0] sec_sum_q, hist_sum_q;
   logic signed [35:0] hist_q [0:7];
   logic [2:0] hist_ptr_q;
   logic [31:0] pend_q;
   logic [7:0] sent_q;

   wire [47:0] quo_full = {quo_q[46:0], rem_ge};
   wire den_zero = (den_q == 32'h0000_0000); // no transit time: report no flow
   wire over = quo_full > 48'(flow_pulse_pkg::RATE_SAT);
   wire [31:0] mag = den_zero ? 32'h0000_0000
      : over ? flow_pulse_pkg::RATE_SAT : quo_full[31:0];
   wire signed [35:0] sample = dt_q[15] ? -36'(mag) : 36'(mag);
   wire div_done = (st_q == flow_pulse_pkg::ST_DIV) && div_last;
   wire signed [35:0] sec_avg = test_q ? (sec_sum_q >>> flow_pulse_pkg::AVG_SHIFT) : sec_sum_q;
   wire signed [35:0] hist_next = hist_sum_q + sec_avg - hist_q[hist_ptr_q];
   wire signed [35:0] flow_avg = hist_sum_q >>> flow_pulse_pkg::AVG_SHIFT;
   wire below = flow_avg[35] || (flow_avg < 36'(MIN_CUT));
   wire [31:0] rate_eff = (below || !ready_q) ? 32'h0000_0000
      : (flow_avg > 36'(flow_pulse_pkg::RATE_SAT)) ? flow_pulse_pkg::RATE_SAT
      : flow_avg[31:0];

   // per-second sum of samples and eight-second history
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sec_sum_q <= 36'sh0_0000_0000;
         hist_sum_q <= 36'sh0_0000_0000;
         hist_ptr_q <= 3'h0;
         for (int i = 0; i < 8; i++)
            hist_q[i] <= 36'sh0_0000_0000;
      end
      else
      begin
         if (sec_tick)
            sec_sum_q <= div_done ? sample : 36'sh0_0000_0000;
         else if (div_done)
            sec_sum_q <= sec_sum_q + sample;
         if (sec_tick)
         begin
            hist_q[hist_ptr_q] <= sec_avg;
            hist_sum_q <= hist_next;
            hist_ptr_q <= hist_ptr_q + 3'h1;
         end
      end
   end

   // volume integration and published rate
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         volume_q <= 48'h0000_0000_0000;
         flow_rate_q <= 32'h0000_0000;
      end
      else if (sec_tick)
      begin
         flow_rate_q <= rate_eff;
         if (!flow_avg[35])
            volume_q <= volume_q + 48'(flow_avg);
      end
   end

   // ----------------------------------------
   // burst emitter
   // ----------------------------------------
   flow_pulse_pkg::emit_state_t em_q, em_d;
   logic [27:0] em_cnt_q;
   logic [5:0] burst_n_q;

   wire can_emit = (pend_q >= flow_pulse_pkg::MILLI) && (sent_q < flow_pulse_pkg::MAX_PULSES);
   wire em_start = (em_q == flow_pulse_pkg::EM_IDLE) && can_emit;
   wire em_high_end = (em_cnt_q == 28'(PULSE_HIGH_CYC - 1));
   wire em_gap_end = (em_cnt_q == 28'(PULSE_GAP_CYC - 1));
   wire em_pause_end = (em_cnt_q == 28'(BURST_PAUSE_CYC - 1));
   wire burst_full = (burst_n_q == flow_pulse_pkg::BURST_LEN - 6'h01);
   wire [31:0] pend_sub = em_start ? pend_q - flow_pulse_pkg::MILLI : pend_q;
   wire [31:0] pend_add = pend_sub + rate_eff;
   wire [31:0] pend_cap = flow_pulse_pkg::RATE_SAT + flow_pulse_pkg::MILLI - 32'h0000_0001;

   // emitter state sequence
   always_comb
   begin
      em_d = em_q;
      case (em_q)
         flow_pulse_pkg::EM_IDLE: if (can_emit) em_d = flow_pulse_pkg::EM_HIGH;
         flow_pulse_pkg::EM_HIGH:
            if (em_high_end)
               em_d = burst_full ? flow_pulse_pkg::EM_PAUSE : flow_pulse_pkg::EM_GAP;
         flow_pulse_pkg::EM_GAP: if (em_gap_end) em_d = flow_pulse_pkg::EM_IDLE;
         flow_pulse_pkg::EM_PAUSE: if (em_pause_end) em_d = flow_pulse_pkg::EM_IDLE;
         default: em_d = flow_pulse_pkg::EM_IDLE;
      endcase
   end

   // pulse timing, budget and remainder carry
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         em_q <= flow_pulse_pkg::EM_IDLE;
         em_cnt_q <= 28'h000_0000;
         burst_n_q <= 6'h00;
         pulse_out_q <= 1'b0;
         pend_q <= 32'h0000_0000;
         sent_q <= 8'h00;
      end
      else
      begin
         em_q <= em_d;
         em_cnt_q <= (em_d != em_q) ? 28'h000_0000 : em_cnt_q + 28'h000_0001;
         pulse_out_q <= (em_d == flow_pulse_pkg::EM_HIGH);
         if (em_q == flow_pulse_pkg::EM_PAUSE)
            burst_n_q <= 6'h00;
         else if (em_q == flow_pulse_pkg::EM_HIGH && em_high_end)
            burst_n_q <= burst_n_q + 6'h01;
         if (sec_tick)
         begin
            sent_q <= em_start ? 8'h01 : 8'h00;
            if (rate_eff == 32'h0000_0000)
               pend_q <= 32'h0000_0000;
            else
               pend_q <= (pend_add > pend_cap) ? pend_cap : pend_add;
         end
         else
         begin
            pend_q <= pend_sub;
            if (em_start)
               sent_q <= sent_q + 8'h01;
         end
      end
   end

endmodule : flow_pulse_emitter

/* File: logic/flow_pulse_pkg.sv */
package flow_pulse_pkg;

   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int SECOND_MS = 1000;
   localparam int FAST_MEAS_MS = 125;
   localparam int WARMUP_S = 16;
   localparam int PULSE_HIGH_US = 3000;
   localparam int PULSE_GAP_US = 3000;
   localparam int BURST_PAUSE_MS = 30;
   localparam int SECOND_CYC = CLK_HZ / 1000 * SECOND_MS;
   localparam int FAST_MEAS_CYC = CLK_HZ / 1000 * FAST_MEAS_MS;
   localparam int WARMUP_CYC = CLK_HZ * WARMUP_S;
   localparam int PULSE_HIGH_CYC = CLK_HZ / 1_000_000 * PULSE_HIGH_US;
   localparam int PULSE_GAP_CYC = CLK_HZ / 1_000_000 * PULSE_GAP_US;
   localparam int BURST_PAUSE_CYC = CLK_HZ / 1000 * BURST_PAUSE_MS;

   // ----------------------------------------
   // rates in milli-pulses per second, counts, gain and shifts
   // ----------------------------------------
   localparam logic [31:0] MILLI = 32'h0000_03E8;
   localparam logic [31:0] RATE_SAT = 32'h0001_E848;
   localparam logic [31:0] MIN_CUT_DEF = 32'h0000_01F4;
   localparam logic [7:0] MAX_PULSES = 8'h7D;
   localparam logic [5:0] BURST_LEN = 6'h20;
   localparam logic [2:0] TOF_SAMPLES = 3'h4;
   localparam logic [15:0] GAIN_DEF = 16'h0010;
   localparam logic [5:0] DIV_STEPS = 6'h30;
   localparam int AVG_SHIFT = 3;
   localparam int TOF_SHIFT = 2;

   // ----------------------------------------
   // state encodings
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_TOF = 2'b01,
      ST_PHASE = 2'b10,
      ST_DIV = 2'b11
   } seq_state_t;

   typedef enum logic [1:0]
   {
      EM_IDLE = 2'b00,
      EM_HIGH = 2'b01,
      EM_GAP = 2'b10,
      EM_PAUSE = 2'b11
   } emit_state_t;

endpackage : flow_pulse_pkg

/* File: verif/flow_front_model.sv */
`timescale 1ns/1ns
module flow_front_model #(
   parameter logic [15:0] TOF_VAL = 16'h0010
)(
   input wire logic clk, // clock
   input wire logic rst_n, // reset, active low
   input wire logic meas_start_q, // request from block
   input wire logic meas_is_phase_q, // request kind
   input wire logic pulse_out_q, // flow pulses
   input wire logic slow, // answer late
   input wire logic [15:0] phase_val, // signed phase to report
   output logic meas_done = 1'b0, // result valid
   output logic [15:0] meas_value = 16'h5A5A, // result
   output logic [15:0] pulse_count // pulses counted
);
   logic pend_q;
   logic [4:0] wait_q;
   logic pulse_q;
   // front end answers each request once; calculator counts rising edges
   always_ff @(posedge clk)
   begin
      meas_done <= 1'b0;
      meas_value <= ~meas_value; // stale value is never held
      pulse_q <= pulse_out_q;
      if (!rst_n)
      begin
         pend_q <= 1'b0;
         pulse_count <= 16'h0000;
      end
      else if (meas_start_q)
      begin
         pend_q <= 1'b1;
         wait_q <= slow ? 5'h10 : 5'h00;
      end
      else if (pend_q && wait_q != 5'h00)
         wait_q <= wait_q - 5'h01;
      else if (pend_q)
      begin
         pend_q <= 1'b0;
         meas_done <= 1'b1;
         meas_value <= meas_is_phase_q ? phase_val : TOF_VAL;
      end
      if (rst_n && pulse_out_q && !pulse_q)
         pulse_count <= pulse_count + 16'h0001;
   end
endmodule : flow_front_model

/* File: verif/flow_pulse_checker.sv */
`timescale 1ns/1ns
module flow_pulse_checker #(
   parameter int WARMUP_CYC = 3200,
   parameter int PULSE_HIGH_CYC = 6,
   parameter int PULSE_GAP_CYC = 6,
   parameter int BURST_PAUSE_CYC = 60,
   parameter logic [31:0] MIN_CUT = flow_pulse_pkg::MIN_CUT_DEF
)(
   input wire logic clk, // clock
   input wire logic rst_n, // reset, active low
   input wire logic meas_start_q, // measurement request
   input wire logic pulse_out_q, // pulse line
   input wire logic ready_q, // warm-up done
   input wire logic [31:0] flow_rate_q, // emitted rate
   input wire logic [47:0] volume_q // volume
);
   int hi_q;
   int lo_q;
   int up_q;
   int burst_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // run lengths of the line, cycles since reset, pulses since a long pause
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         hi_q <= 0;
         lo_q <= 0;
         up_q <= 0;
         burst_q <= 0;
      end
      else
      begin
         hi_q <= pulse_out_q ? hi_q + 1 : 0;
         lo_q <= pulse_out_q ? 0 : lo_q + 1;
         up_q <= up_q + 1;
         if (pulse_out_q && hi_q == 0)
            burst_q <= (lo_q >= BURST_PAUSE_CYC) ? 1 : burst_q + 1;
      end
   end
   pulse_width_a: assert property ($fell(pulse_out_q) |-> hi_q == PULSE_HIGH_CYC)
      else $error("pulse high time wrong");
   pulse_gap_a: assert property ($rose(pulse_out_q) |-> lo_q >= PULSE_GAP_CYC)
      else $error("pulse gap too short");
   burst_len_a: assert property (burst_q <= 32)
      else $error("burst without pause");
   quiet_unready_a: assert property (!ready_q |-> !pulse_out_q)
      else $error("pulse before ready");
   ready_stay_a: assert property (ready_q |-> up_q >= WARMUP_CYC - 1 ##1 ready_q)
      else $error("ready early or dropped");
   rate_cap_a: assert property (flow_rate_q <= flow_pulse_pkg::RATE_SAT)
      else $error("rate above clamp");
   rate_cut_a: assert property (flow_rate_q != 0 |-> flow_rate_q >= MIN_CUT)
      else $error("rate below cut-off");
   volume_grow_a: assert property (volume_q >= $past(volume_q))
      else $error("volume decreased");
   start_single_a: assert property (meas_start_q |=> !meas_start_q)
      else $error("request longer than one cycle");
   cover property ($rose(pulse_out_q));
   cover property (flow_rate_q == flow_pulse_pkg::RATE_SAT);
   cover property ($rose(ready_q));
endmodule : flow_pulse_checker

bind flow_pulse_emitter flow_pulse_checker #(.WARMUP_CYC(WARMUP_CYC),
   .PULSE_HIGH_CYC(PULSE_HIGH_CYC), .PULSE_GAP_CYC(PULSE_GAP_CYC),
   .BURST_PAUSE_CYC(BURST_PAUSE_CYC), .MIN_CUT(MIN_CUT)) flow_pulse_checker_i (.clk(clk),
   .rst_n(rst_n), .meas_start_q(meas_start_q), .pulse_out_q(pulse_out_q),
   .ready_q(ready_q), .flow_rate_q(flow_rate_q), .volume_q(volume_q));

/* File: verif/flow_pulse_emitter_tb.sv */
`timescale 1ns/1ns
module flow_pulse_emitter_tb;
   localparam int SEC = 1800;
   typedef struct {
      logic [15:0] dt;
      logic [15:0] mf;
      logic tm;
      logic slow;
      logic [31:0] rate;
      logic [15:0] pulses;
   } row_t;
   row_t rows [4];
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic test_mode = 1'b0;
   logic [15:0] meter_factor = 16'h03E8;
   logic slow = 1'b0;
   logic [15:0] phase_val = 16'h0000;
   logic meas_done;
   logic [15:0] meas_value;
   logic meas_start_q;
   logic meas_is_phase_q;
   logic pulse_out_q;
   logic ready_q;
   logic [31:0] flow_rate_q;
   logic [47:0] volume_q;
   logic [15:0] pulse_count;
   logic [15:0] c0;
   int failures = 0;
   int comparisons = 0;
   flow_pulse_emitter #(.SECOND_CYC(SEC), .FAST_MEAS_CYC(SEC / 8), .WARMUP_CYC(SEC),
      .PULSE_HIGH_CYC(5), .PULSE_GAP_CYC(5), .BURST_PAUSE_CYC(54)) flow_pulse_emitter_i (
      .clk(clk), .rst_n(rst_n), .test_mode(test_mode), .meter_factor(meter_factor),
      .meas_done(meas_done), .meas_value(meas_value), .meas_start_q(meas_start_q),
      .meas_is_phase_q(meas_is_phase_q), .pulse_out_q(pulse_out_q), .ready_q(ready_q),
      .flow_rate_q(flow_rate_q), .volume_q(volume_q));
   flow_front_model flow_front_model_i (.clk(clk), .rst_n(rst_n),
      .meas_start_q(meas_start_q), .meas_is_phase_q(meas_is_phase_q),
      .pulse_out_q(pulse_out_q), .slow(slow), .phase_val(phase_val),
      .meas_done(meas_done), .meas_value(meas_value), .pulse_count(pulse_count));
   // 10 MHz clock
   initial
   begin
      forever #50 clk = ~clk;
   end
   task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic results();
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results
   task automatic zeros();
      check("outputs in reset", {44'h0, meas_start_q, meas_is_phase_q, pulse_out_q, ready_q},
         48'h0);
      check("rate in reset", {16'h0, flow_rate_q}, 48'h0);
      check("volume in reset", volume_q, 48'h0);
   endtask : zeros
   task automatic warm();
      int n;
      repeat (SEC - 20) @(negedge clk);
      check("ready early", {47'h0, ready_q}, 48'h0);
      n = 0;
      while (ready_q !== 1'b1 && n < 40)
      begin
         @(negedge clk);
         n++;
      end
      check("ready", {47'h0, ready_q}, 48'h1);
      if (ready_q !== 1'b1)
         results();
   endtask : warm
   // table of flows, then reset in mid-run
   initial
   begin
      rows[0] = '{16'h0020, 16'h0BB8, 1'b1, 1'b0, 32'h0000_1770, 16'h000C};
      rows[1] = '{16'h1000, 16'h03E8, 1'b0, 1'b0, 32'h0001_E848, 16'h00FA};
      rows[2] = '{16'hF000, 16'h03E8, 1'b0, 1'b1, 32'h0000_0000, 16'h0000};
      rows[3] = '{16'h0004, 16'h03E8, 1'b1, 1'b0, 32'h0000_0000, 16'h0000};
      repeat (12) @(negedge clk);
      zeros();
      rst_n <= 1'b1;
      warm();
      foreach (rows[i])
      begin
         phase_val <= rows[i].dt;
         meter_factor <= rows[i].mf;
         test_mode <= rows[i].tm;
         slow <= rows[i].slow;
         repeat (9 * SEC) @(negedge clk);
         c0 = pulse_count;
         repeat (2 * SEC) @(negedge clk);
         check("rate", {16'h0, flow_rate_q}, {16'h0, rows[i].rate});
         check("pulses", {32'h0, pulse_count - c0}, {32'h0, rows[i].pulses});
         check("volume", {47'h0, volume_q != 48'h0}, 48'h1);
      end
      rst_n <= 1'b0;
      repeat (2) @(negedge clk);
      zeros();
      rst_n <= 1'b1;
      warm();
      results();
   end
endmodule : flow_pulse_emitter_tb
